// ===== rtl/sacs_pkg.sv
package sacs_pkg;
	// ===========================================================================
	// Control byte layout
	localparam int unsigned OP_HI_BIT   = 7;
	localparam int unsigned OP_LO_BIT   = 6;
	localparam int unsigned ACQ_BIT     = 5;
	localparam int unsigned CFG_BIT     = 4;
	localparam int unsigned POL_BIT     = 3;
	localparam int unsigned ADDR_MSB    = 2;
	localparam int unsigned ADDR_LSB    = 0;
	// ===========================================================================
	// Operation codes held in the top two control bits
	localparam logic [1:0]  OP_FULL_PD  = 2'h0;
	localparam logic [1:0]  OP_STBY_PD  = 2'h1;
	localparam logic [1:0]  OP_INT_CLK  = 2'h2;
	localparam logic [1:0]  OP_EXT_CLK  = 2'h3;
	// ===========================================================================
	// Timing
	localparam int unsigned RES_BITS      = 10;
	localparam int unsigned CONV_CYCLES   = 13;
	localparam int unsigned ACQ_FALL_EDGE = 4;
	localparam int unsigned CLK_MHZ       = 200;
	localparam int unsigned INT_ACQ_NS    = 1000;
	// Internal conversion clock: four periods span the internal acquisition time.
	localparam int unsigned INT_HALF_CYC  = (INT_ACQ_NS * CLK_MHZ) / (1000 * ACQ_FALL_EDGE * 2);
	localparam int unsigned PRE_BITS      = CONV_CYCLES - RES_BITS;
	localparam logic [7:0]  CTRL_RESET    = 8'hc0;
endpackage : sacs_pkg

// ===== rtl/sacs_clk_gen.sv
// Produces the conversion clock falling-edge enable from either source.
module sacs_clk_gen #(
	parameter int unsigned HALF_CYC = sacs_pkg::INT_HALF_CYC
) (
	input  wire logic clk_i,
	input  wire logic rstn_i,
	input  wire logic ext_sel_i,
	input  wire logic ext_clk_i,
	input  wire logic restart_i,
	output logic      fall_o
);
	logic [15:0] cnt_q, cnt_d;
	logic        phase_q, phase_d;
	logic        ext_q, ext_d;
	logic        fall;

	always_comb begin
		cnt_d   = cnt_q;
		phase_d = phase_q;
		ext_d   = ext_clk_i;
		fall    = 1'b0;
		if (ext_sel_i) begin
			fall = ext_q & ~ext_clk_i;
		end else if (restart_i) begin
			cnt_d   = 16'h0000;
			phase_d = 1'b0;
		end else if (cnt_q == 16'(HALF_CYC - 1)) begin
			cnt_d   = 16'h0000;
			phase_d = ~phase_q;
			fall    = phase_q;
		end else begin
			cnt_d = cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			cnt_q   <= 16'h0000;
			phase_q <= 1'b0;
			ext_q   <= 1'b0;
		end else begin
			cnt_q   <= cnt_d;
			phase_q <= phase_d;
			ext_q   <= ext_d;
		end
	end

	assign fall_o = fall;
endmodule : sacs_clk_gen

// ===== rtl/sacs_seq.sv
// What this block does
// - Write rising edge starts tracking.
// - External acquisition: next write edge with acquisition bit clear holds.
// - Internal acquisition: fourth conversion-clock fall holds.
// - Internal clock: acquisition ends near one microsecond.
// - Valid write needs chip and write select.
// - Sample at acquisition end; conversion follows.
// - Acquisition bit picks internal or host timing.
// - Conversion lasts thirteen conversion-clock cycles.
// - New write aborts conversion, restarts acquisition.
// - Single-ended: channel positive, common negative.
// - Pseudo-differential: pair picks both inputs.
// - Ten-bit result read as eight plus two.
// - Completion flag low when done; cleared by read/write.
// - Upper select picks high two or low eight.
// - Top bits pick power-down or clock mode.
module sacs_seq #(
	parameter int unsigned CHANNELS = 8
) (
	input  wire logic       clk_i,
	input  wire logic       rstn_i,
	input  wire logic       cs_n_i,
	input  wire logic       wr_n_i,
	input  wire logic       rd_n_i,
	input  wire logic       upper_part_select_i,
	input  wire logic [7:0] data_i,
	input  wire logic       conv_clk_i,
	input  wire logic       comp_i,
	output logic [7:0]      data_o,
	output logic            data_oe_o,
	output logic            done_n_o,
	output logic            track_o,
	output logic            convert_o,
	output logic [9:0]      dac_trial_o,
	output logic [2:0]      pos_channel_o,
	output logic [2:0]      neg_channel_o,
	output logic            neg_is_common_o,
	output logic            polarity_select_o,
	output logic            full_powerdown_o,
	output logic            standby_o
);
	// ===========================================================================
	// Sequencer state
	typedef enum logic [1:0] {
		SACS_IDLE  = 2'b00,
		SACS_TRACK = 2'b01,
		SACS_CONV  = 2'b10
	} sacs_state_t;

	sacs_state_t state_q, state_d;
	logic [7:0]  ctrl_q, ctrl_d;
	logic        ext_clk_q, ext_clk_d;
	logic [3:0]  cyc_q, cyc_d;
	logic [9:0]  sar_q, sar_d;
	logic [9:0]  res_q, res_d;
	logic        done_n_q, done_n_d;
	logic        wr_n_q, rd_n_q;
	logic [7:0]  dout_q, dout_d;
	logic        fall;
	logic        wr_rise;
	logic        rd_fall;
	logic        ext_acq;

	// Write is qualified by chip select at the rising edge of write select.
	assign wr_rise = ~cs_n_i & wr_n_i & ~wr_n_q;
	assign rd_fall = ~cs_n_i & ~rd_n_i & rd_n_q;
	assign ext_acq = ctrl_q[sacs_pkg::ACQ_BIT];

	sacs_clk_gen u_clk_gen (
		.clk_i     (clk_i),
		.rstn_i    (rstn_i),
		.ext_sel_i (ext_clk_q),
		.ext_clk_i (conv_clk_i),
		.restart_i (wr_rise),
		.fall_o    (fall)
	);

	// ===========================================================================
	// Control byte and sequencing
	always_comb begin
		state_d   = state_q;
		ctrl_d    = ctrl_q;
		ext_clk_d = ext_clk_q;
		cyc_d     = cyc_q;
		sar_d     = sar_q;
		res_d     = res_q;
		done_n_d  = done_n_q;
		if (wr_rise) begin
			ctrl_d   = data_i;
			done_n_d = 1'b1;
			cyc_d    = 4'h0;
			// Clock mode is kept when a power-down code is written.
			if (data_i[sacs_pkg::OP_HI_BIT]) begin
				ext_clk_d = data_i[sacs_pkg::OP_LO_BIT];
			end
			if (state_q == SACS_TRACK && ext_acq && !data_i[sacs_pkg::ACQ_BIT]) begin
				// This write still loads the whole control byte, address included.
				state_d = SACS_CONV;
				sar_d   = 10'h000;
			end else begin
				state_d = SACS_TRACK;
			end
		end else begin
			if (rd_fall) begin
				done_n_d = 1'b1;
			end
			unique case (state_q)
				SACS_IDLE: begin
				end
				SACS_TRACK: begin
					// Internal timing counts conversion-clock falls after the write.
					if (!ext_acq && fall) begin
						cyc_d = cyc_q + 4'h1;
						if (cyc_q == 4'(sacs_pkg::ACQ_FALL_EDGE - 1)) begin
							state_d = SACS_CONV;
							cyc_d   = 4'h0;
							sar_d   = 10'h000;
						end
					end
				end
				SACS_CONV: begin
					if (fall) begin
						cyc_d = cyc_q + 4'h1;
						if (cyc_q >= 4'(sacs_pkg::PRE_BITS)) begin
							// Bit under trial is kept when the comparator says so.
							sar_d = sar_q | (comp_i ? trial_bit(cyc_q) : 10'h000);
						end
						if (cyc_q == 4'(sacs_pkg::CONV_CYCLES - 1)) begin
							state_d  = SACS_IDLE;
							res_d    = sar_q | (comp_i ? trial_bit(cyc_q) : 10'h000);
							done_n_d = 1'b0;
						end
					end
				end
				default: state_d = SACS_IDLE;
			endcase
		end
	end

	// Trial weight for conversion cycle n, MSB first after the settle cycles.
	function automatic logic [9:0] trial_bit(input logic [3:0] n);
		logic [3:0] k;
		k = 4'(sacs_pkg::CONV_CYCLES - 1) - n;
		trial_bit = 10'h001 << k;
	endfunction : trial_bit

	// ===========================================================================
	// Read mux
	always_comb begin
		dout_d = dout_q;
		if (!cs_n_i && !rd_n_i) begin
			dout_d = upper_part_select_i ? {6'h00, res_q[9:8]} : res_q[7:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			state_q   <= SACS_IDLE;
			ctrl_q    <= sacs_pkg::CTRL_RESET;
			ext_clk_q <= 1'b1;
			cyc_q     <= 4'h0;
			sar_q     <= 10'h000;
			res_q     <= 10'h000;
			done_n_q  <= 1'b1;
			wr_n_q    <= 1'b1;
			rd_n_q    <= 1'b1;
			dout_q    <= 8'h00;
		end else begin
			state_q   <= state_d;
			ctrl_q    <= ctrl_d;
			ext_clk_q <= ext_clk_d;
			cyc_q     <= cyc_d;
			sar_q     <= sar_d;
			res_q     <= res_d;
			done_n_q  <= done_n_d;
			wr_n_q    <= wr_n_i;
			rd_n_q    <= rd_n_i;
			dout_q    <= dout_d;
		end
	end

	// ===========================================================================
	// Outputs
	logic [2:0] addr;
	logic [2:0] addr_m;
	assign addr   = ctrl_q[sacs_pkg::ADDR_MSB:sacs_pkg::ADDR_LSB];
	// Smaller variants ignore address bits above their channel count.
	assign addr_m = addr & 3'(CHANNELS - 1);

	assign data_o            = dout_q;
	assign data_oe_o         = ~cs_n_i & ~rd_n_i;
	assign done_n_o          = done_n_q;
	assign track_o           = (state_q == SACS_TRACK);
	assign convert_o         = (state_q == SACS_CONV);
	assign dac_trial_o       = (state_q == SACS_CONV && cyc_q >= 4'(sacs_pkg::PRE_BITS)) ? (sar_q | trial_bit(cyc_q))
	                                                                                   : sar_q;
	// Pairs are even/odd neighbours; the low address bit swaps the sense.
	assign pos_channel_o     = ctrl_q[sacs_pkg::CFG_BIT] ? addr_m : {addr_m[2:1], addr_m[0]};
	assign neg_channel_o     = {addr_m[2:1], ~addr_m[0]};
	assign neg_is_common_o   = ctrl_q[sacs_pkg::CFG_BIT];
	assign polarity_select_o = ctrl_q[sacs_pkg::POL_BIT];
	assign full_powerdown_o  = (ctrl_q[7:6] == sacs_pkg::OP_FULL_PD) && (state_q == SACS_IDLE);
	assign standby_o         = (ctrl_q[7:6] == sacs_pkg::OP_STBY_PD) && (state_q == SACS_IDLE);
endmodule : sacs_seq

// ===== dv/sacs_seq_chk.sv
module sacs_seq_chk (
	input wire logic       clk_i,
	input wire logic       rstn_i,
	input wire logic       cs_n_i,
	input wire logic       wr_n_i,
	input wire logic       rd_n_i,
	input wire logic [7:0] data_i,
	input wire logic       conv_clk_i,
	input wire logic       data_oe_o,
	input wire logic       done_n_o,
	input wire logic       track_o,
	input wire logic       convert_o,
	input wire logic [2:0] pos_channel_o,
	input wire logic [2:0] neg_channel_o,
	input wire logic       neg_is_common_o,
	input wire logic       full_powerdown_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	logic       wr_q, cc_q, ext_q, acq_q, wv, fall;
	logic [3:0] tcnt_q, ccnt_q;
	logic [1:0] op_q;
	assign wv = wr_n_i && !wr_q && !cs_n_i;
	assign fall = cc_q && !conv_clk_i;
	// Fall counts only mean something in external clock mode; ext_q follows the clock-mode code.
	always_ff @(posedge clk_i) begin
		wr_q <= !rstn_i || wr_n_i;
		cc_q <= conv_clk_i;
		ext_q <= !rstn_i || ((wv && data_i[7]) ? data_i[6] : ext_q);
		acq_q <= rstn_i && (wv ? data_i[5] : acq_q);
		op_q <= !rstn_i ? 2'h3 : (wv ? data_i[7:6] : op_q);
		tcnt_q <= (wv || !track_o) ? 4'h0 : tcnt_q + 4'(fall);
		ccnt_q <= !convert_o ? 4'h0 : ccnt_q + 4'(fall);
	end
	chk_oe_read: assert property (data_oe_o == (!cs_n_i && !rd_n_i)) else $error("bus enable wrong");
	chk_write_track: assert property (wv && !(track_o && acq_q) |=> track_o && done_n_o)
		else $error("write did not start tracking");
	chk_ext_hold: assert property (wv && track_o && acq_q && !data_i[5] |=> convert_o && !track_o)
		else $error("second write did not hold");
	chk_int_hold: assert property (ext_q && !acq_q && $rose(convert_o) && !$past(wv) |-> tcnt_q == 4'h4)
		else $error("hold not on fourth fall");
	chk_conv_len: assert property (ext_q && $fell(convert_o) && !done_n_o |-> ccnt_q == 4'hd)
		else $error("conversion length wrong");
	chk_write_abort: assert property (wv && convert_o |=> track_o && !convert_o) else $error("no abort");
	chk_done_hold: assert property (!done_n_o && !wv && (cs_n_i || rd_n_i) |=> !done_n_o)
		else $error("flag dropped early");
	chk_read_clear: assert property ($fell(rd_n_i) && !cs_n_i |=> done_n_o) else $error("read kept flag");
	chk_input_route: assert property (wv |=> pos_channel_o == $past(data_i[2:0])
		&& neg_is_common_o == $past(data_i[4]) && (neg_is_common_o || neg_channel_o == (pos_channel_o ^ 3'h1)))
		else $error("channel routing wrong");
	// Power-down only takes effect once the sequencer is idle again.
	chk_op_decode: assert property (full_powerdown_o == (op_q == sacs_pkg::OP_FULL_PD && !track_o && !convert_o))
		else $error("power code wrong");
endmodule : sacs_seq_chk
bind sacs_seq sacs_seq_chk sacs_seq_chk_inst (.*);

// ===== dv/sacs_analog_model.sv
module sacs_analog_model (
	input  wire logic [9:0] dac_trial_i,
	input  wire logic [9:0] level_i,
	output logic            comp_o
);
	timeunit 1ns;
	timeprecision 1ps;
	assign comp_o = dac_trial_i <= level_i;
endmodule : sacs_analog_model

// ===== dv/sacs_seq_tb_top.sv
module sacs_seq_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk_i, rstn_i, cs_n_i, wr_n_i, rd_n_i, upper_part_select_i, conv_clk_i, comp_i;
	logic       data_oe_o, done_n_o, track_o, convert_o, neg_is_common_o, polarity_select_o;
	logic       full_powerdown_o, standby_o;
	logic [7:0] data_i, data_o;
	logic [9:0] dac_trial_o, vin;
	logic [2:0] pos_channel_o, neg_channel_o;
	int         errors, checks_done, cyc;
	sacs_seq sacs_seq_inst (.*);
	sacs_analog_model sacs_analog_model_inst (.dac_trial_i(dac_trial_o), .level_i(vin), .comp_o(comp_i));
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	// Conversion clock runs from the cycle count so that writes can keep clear of its edges.
	always @(posedge clk_i) begin
		cyc++;
		#1 conv_clk_i = cyc[2];
		if (cyc > 20000) begin
			errors++;
			summarize();
		end
	end
	task automatic chk(string name, logic [9:0] exp, logic [9:0] got);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic wr(logic [7:0] b, logic cs = 1'b0);
		do begin
			@(posedge clk_i);
			#1;
		end while (cyc[1:0] != 2'h1);
		cs_n_i = cs;
		wr_n_i = 1'b0;
		data_i = b;
		@(posedge clk_i);
		#1 wr_n_i = 1'b1;
		@(posedge clk_i);
		#1 cs_n_i = 1'b1;
	endtask : wr
	task automatic rd(logic hi, output logic [7:0] q);
		@(posedge clk_i);
		#1 cs_n_i = 1'b0;
		rd_n_i = 1'b0;
		upper_part_select_i = hi;
		repeat (2) @(posedge clk_i);
		#1 q = data_o;
		cs_n_i = 1'b1;
		rd_n_i = 1'b1;
	endtask : rd
	task automatic conv(logic [7:0] b, logic [9:0] v);
		logic [7:0] lo, hi;
		vin = v;
		wr(b);
		for (int i = 0; i < 3000 && done_n_o !== 1'b0; i++) begin
			@(posedge clk_i);
			#1;
		end
		chk("done flag", 10'h0, {9'h0, done_n_o});
		rd(1'b0, lo);
		chk("low part", v & 10'hff, {2'h0, lo});
		rd(1'b1, hi);
		chk("high part", v >> 8, {8'h0, hi[1:0]});
		chk("flag after read", 10'h1, {9'h0, done_n_o});
	endtask : conv
	task automatic summarize();
		$display("Checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : summarize
	initial begin
		{rstn_i, cs_n_i, wr_n_i, rd_n_i, upper_part_select_i, conv_clk_i} = 6'h1e;
		data_i = 8'h0;
		vin = 10'h0;
		repeat (16) @(posedge clk_i);
		#1 rstn_i = 1'b1;
		chk("power code after reset", 10'h0, {9'h0, full_powerdown_o});
		conv(8'hdd, 10'h2a5);
		wr(8'hed);
		repeat (100) @(posedge clk_i);
		#1 chk("host-timed tracking", 10'h1, {9'h0, track_o});
		conv(8'hcd, 10'h13c);
		chk("pair negative input", 10'h4, {7'h0, neg_channel_o});
		chk("pair positive input", 10'h5, {7'h0, pos_channel_o});
		chk("polarity", 10'h1, {9'h0, polarity_select_o});
		wr(8'hdd);
		for (int i = 0; i < 200 && convert_o !== 1'b1; i++) @(posedge clk_i);
		conv(8'hdd, 10'h001);
		wr(8'hdd, 1'b1);
		repeat (8) @(posedge clk_i);
		#1 chk("write without select", 10'h0, {9'h0, track_o});
		for (int op = 0; op < 4; op++) begin
			wr({op[1:0], 6'h1d});
			// Power-down modes apply only after the started conversion has completed.
			for (int i = 0; i < 1000 && done_n_o !== 1'b0; i++) begin
				@(posedge clk_i);
				#1;
			end
			chk("full powerdown", {9'h0, op == 0}, {9'h0, full_powerdown_o});
			chk("standby", {9'h0, op == 1}, {9'h0, standby_o});
		end
		conv(8'h9d, 10'h155);
		summarize();
	end
endmodule : sacs_seq_tb_top
